// file: hw/tsc_pkg.sv

package tsc_pkg;

    typedef enum logic [2:0] {
        TSC_M0 = 3'b000,
        TSC_M1 = 3'b001,
        TSC_M2 = 3'b010,
        TSC_M3 = 3'b011,
        TSC_M4 = 3'b100,
        TSC_M5 = 3'b101
    } tsc_mode_t;

    localparam int          TSC_BW      = 16;
    localparam logic [15:0] TSC_CNT_RST = 16'h0000;
    localparam logic [15:0] TSC_BIN_MAX = 16'hFFFF;
    localparam logic [15:0] TSC_BCD_MAX = 16'h9999;
    localparam logic [15:0] TSC_ONE     = 16'h0001;
    localparam logic [15:0] TSC_TWO     = 16'h0002;
    localparam logic [15:0] TSC_THREE   = 16'h0003;
    localparam logic [3:0]  TSC_DIG_MAX = 4'h9;
    localparam tsc_mode_t   TSC_MODE_RST = TSC_M0;
    localparam logic        TSC_OUT_RST = 1'b0;

endpackage

// file: hw/tsc_channel.sv
`timescale 1ns/1ns
`default_nettype none

module tsc_channel (
    // System clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // Host programming strobes
    input  wire logic                       setup_wr,
    input  wire tsc_pkg::tsc_mode_t         setup_mode,
    input  wire logic                       setup_bcd,
    input  wire logic                       count_wr,
    input  wire logic [tsc_pkg::TSC_BW-1:0] count_val,
    // Channel pins
    input  wire logic                       cnt_clk,
    input  wire logic                       gate,
    output logic                            cnt_out,
    output logic [tsc_pkg::TSC_BW-1:0]      count_now
);
    import tsc_pkg::*;

    // One step down; decimal digits borrow so no digit ever exceeds nine.
    function automatic logic [15:0] dec1(input logic [15:0] v,
                                         input logic bcd);
        logic [15:0] r;
        logic        borrow;
        r = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - TSC_ONE;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (borrow) begin
                    if (v[i*4 +: 4] == 4'h0) begin
                        r[i*4 +: 4] = TSC_DIG_MAX;
                    end else begin
                        r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    logic        cclk_s1_reg, cclk_s2_reg, cclk_s3_reg;
    logic        gate_s1_reg, gate_s2_reg, gate_s3_reg;
    tsc_mode_t   mode_reg, mode_next;
    logic        bcd_reg, bcd_next;
    logic [15:0] init_reg, init_next;
    logic [15:0] count_reg, count_next;
    logic        out_reg, out_next;
    logic        pend_reg, pend_next;
    logic        run_reg, run_next;
    logic        armed_reg, armed_next;
    logic        done_reg, done_next;
    logic        trig_ff_reg, trig_ff_next;
    logic        trig_smp_reg, trig_smp_next;
    logic        gate_lvl_reg;

    // The link clock is sampled, not used as a clock, so the whole channel
    // stays in one domain; pin rates must stay well below a quarter of sys_clk.
    wire rise_ev   = cclk_s2_reg & ~cclk_s3_reg;
    wire fall_ev   = ~cclk_s2_reg & cclk_s3_reg;
    wire gate_rise = gate_s2_reg & ~gate_s3_reg;
    wire periodic  = (mode_reg == TSC_M2) || (mode_reg == TSC_M3);
    wire edge_mode = periodic || (mode_reg == TSC_M1)
                     || (mode_reg == TSC_M5);
    wire sw_load   = (mode_reg == TSC_M0) || (mode_reg == TSC_M4);
    wire cnt_en    = edge_mode && !periodic ? 1'b1 : gate_lvl_reg;
    wire load_go   = sw_load ? pend_reg
                   : periodic ? (pend_reg | trig_smp_reg)
                   : (trig_smp_reg & armed_reg);
    wire [15:0] d1 = dec1(count_reg, bcd_reg);
    wire [15:0] d2 = dec1(d1, bcd_reg);
    wire [15:0] d3 = dec1(d2, bcd_reg);
    wire [15:0] sq_step = !count_reg[0] ? TSC_TWO
                        : (out_reg ? TSC_ONE : TSC_THREE);
    wire [15:0] sq_next = !count_reg[0] ? d2 : (out_reg ? d1 : d3);
    wire        d1_zero = (d1 == TSC_CNT_RST);

    // Edge capture: a trigger is held until the next rising clock reads it.
    assign trig_ff_next  = (gate_rise & edge_mode)
                           | (trig_ff_reg & ~rise_ev & ~setup_wr);
    // A setup word drops a sampled trigger so no stale load follows it.
    assign trig_smp_next = setup_wr ? 1'b0
                         : rise_ev ? trig_ff_reg
                         : (fall_ev ? 1'b0 : trig_smp_reg);

    always_comb begin
        mode_next  = mode_reg;
        bcd_next   = bcd_reg;
        init_next  = init_reg;
        count_next = count_reg;
        out_next   = out_reg;
        pend_next  = pend_reg;
        run_next   = run_reg;
        armed_next = armed_reg;
        done_next  = done_reg;
        if (setup_wr) begin
            // Control logic clears in the write cycle itself.
            mode_next  = setup_mode;
            bcd_next   = setup_bcd;
            out_next   = (setup_mode != TSC_M0);
            pend_next  = 1'b0;
            run_next   = 1'b0;
            armed_next = 1'b0;
            done_next  = 1'b0;
        end else begin
            if (fall_ev && load_go) begin
                // The loading edge never decrements.
                count_next = init_reg;
                pend_next  = 1'b0;
                run_next   = 1'b1;
                done_next  = 1'b0;
                if (mode_reg == TSC_M1) begin
                    out_next = 1'b0;
                end
                if (mode_reg == TSC_M2 || mode_reg == TSC_M4
                    || mode_reg == TSC_M5) begin
                    // A reload ends a strobe in progress.
                    out_next = 1'b1;
                end
            end else if (fall_ev && run_reg && cnt_en) begin
                case (mode_reg)
                    TSC_M0, TSC_M1: begin
                        count_next = d1;
                        if (d1_zero) begin
                            out_next = 1'b1;
                        end
                    end
                    TSC_M2: begin
                        if (count_reg == TSC_ONE) begin
                            count_next = init_reg;
                            out_next   = 1'b1;
                        end else begin
                            count_next = d1;
                            out_next   = (d1 != TSC_ONE);
                        end
                    end
                    TSC_M3: begin
                        if (count_reg == sq_step) begin
                            count_next = init_reg;
                            out_next   = ~out_reg;
                        end else begin
                            count_next = sq_next;
                        end
                    end
                    default: begin
                        // Wraps on; the strobe fires once per load.
                        count_next = d1;
                        out_next   = ~(d1_zero & ~done_reg);
                        if (d1_zero) begin
                            done_next = 1'b1;
                        end
                    end
                endcase
            end
            if (count_wr) begin
                // Running periodic modes and the triggered strobe mode M5 keep running on the old count.
                init_next  = count_val;
                armed_next = 1'b1;
                if (sw_load || (periodic && !run_reg)) begin
                    pend_next = 1'b1;
                end
                if (mode_reg == TSC_M0) begin
                    out_next = 1'b0;
                end
            end
            if (periodic && !gate_s2_reg) begin
                out_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cclk_s1_reg  <= 1'b0;
            cclk_s2_reg  <= 1'b0;
            cclk_s3_reg  <= 1'b0;
            gate_s1_reg  <= 1'b0;
            gate_s2_reg  <= 1'b0;
            gate_s3_reg  <= 1'b0;
            gate_lvl_reg <= 1'b0;
            trig_ff_reg  <= 1'b0;
            trig_smp_reg <= 1'b0;
        end else begin
            cclk_s1_reg  <= cnt_clk;
            cclk_s2_reg  <= cclk_s1_reg;
            cclk_s3_reg  <= cclk_s2_reg;
            gate_s1_reg  <= gate;
            gate_s2_reg  <= gate_s1_reg;
            gate_s3_reg  <= gate_s2_reg;
            if (rise_ev) begin
                gate_lvl_reg <= gate_s2_reg;
            end
            trig_ff_reg  <= trig_ff_next;
            trig_smp_reg <= trig_smp_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mode_reg  <= TSC_MODE_RST;
            bcd_reg   <= 1'b0;
            init_reg  <= TSC_CNT_RST;
            count_reg <= TSC_CNT_RST;
            out_reg   <= TSC_OUT_RST;
            pend_reg  <= 1'b0;
            run_reg   <= 1'b0;
            armed_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            mode_reg  <= mode_next;
            bcd_reg   <= bcd_next;
            init_reg  <= init_next;
            count_reg <= count_next;
            out_reg   <= out_next;
            pend_reg  <= pend_next;
            run_reg   <= run_next;
            armed_reg <= armed_next;
            done_reg  <= done_next;
        end
    end

    assign cnt_out   = out_reg;
    assign count_now = count_reg;

    wire m5 = (mode_reg == TSC_M5);

    a_setup_out_level: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        setup_wr |=> (out_reg == (mode_reg != TSC_M0)))
        else $error("setup word did not set output level");
    a_strobe_one_clk: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (m5 && !out_reg && fall_ev && !setup_wr) |=> out_reg)
        else $error("strobe lasted more than one channel clock");
    a_trig_load_init: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (m5 && fall_ev && trig_smp_reg && armed_reg && !setup_wr)
        |=> (count_reg == $past(init_reg)))
        else $error("trigger did not load initial count");
    a_write_no_load: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (m5 && count_wr && !fall_ev && !setup_wr) |=> $stable(count_reg))
        else $error("count write changed the strobe counter");
    a_gate_no_out: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (m5 && !fall_ev && !setup_wr) |=> $stable(out_reg))
        else $error("gate moved strobe output between clocks");
    a_edge_capture: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (gate_rise && edge_mode) |=> trig_ff_reg ##1 1'b1 [*1])
        else $error("gate rise not captured");
    a_capture_sampled: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (trig_ff_reg && rise_ev && !gate_rise && !setup_wr)
        |=> (trig_smp_reg && !trig_ff_reg))
        else $error("captured trigger not sampled and cleared");
    a_wrap_binary: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (m5 && fall_ev && run_reg && !load_go && !bcd_reg && !setup_wr
         && count_reg == TSC_CNT_RST) |=> (count_reg == TSC_BIN_MAX))
        else $error("counter did not wrap to all ones");
    a_wrap_decimal: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (m5 && fall_ev && run_reg && !load_go && bcd_reg && !setup_wr
         && count_reg == TSC_CNT_RST) |=> (count_reg == TSC_BCD_MAX))
        else $error("decimal counter did not wrap to 9999");
    a_periodic_gate: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (periodic && !gate_s2_reg && !setup_wr) |=> out_reg)
        else $error("periodic output not high with gate low");
    a_rate_reload: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (mode_reg == TSC_M2 && fall_ev && run_reg && cnt_en && !load_go
         && !setup_wr && count_reg == TSC_ONE)
        |=> (count_reg == $past(init_reg)))
        else $error("rate mode did not reload");
    a_oneshot_start: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (mode_reg == TSC_M1 && fall_ev && load_go && !setup_wr) |=> !out_reg)
        else $error("one-shot output did not go low after trigger");

endmodule

`default_nettype wire

// file: dv/tsc_pin_source.sv
`timescale 1ns/1ns
`default_nettype none

module tsc_pin_source (
    // Pacing clock
    input  wire logic sys_clk,
    // Channel pins
    output var logic  cnt_clk,
    output var logic  gate
);

    initial begin
        cnt_clk = 1'b0;
        gate    = 1'b0;
    end

    // Each phase lasts six cycles, so the synchronised edge lands inside it.
    task automatic half(input logic lvl);
        cnt_clk = lvl;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    // A short gate pulse that is gone long before the next clock rise.
    task automatic trigger(input int hold);
        gate = 1'b1;
        repeat (hold) @(posedge sys_clk);
        #1 gate = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // Waits out the synchroniser so the edge is not raced by the clock.
    task automatic level(input logic lvl);
        gate = lvl;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

endmodule

`default_nettype wire

// file: dv/triggered_strobe_counter_channel_test.sv
`timescale 1ns/1ns
`default_nettype none

module triggered_strobe_counter_channel_test;
    import tsc_pkg::*;

    logic             sys_clk;
    logic             resetn;
    logic             setup_wr;
    tsc_mode_t        setup_mode;
    logic             setup_bcd;
    logic             count_wr;
    logic [15:0]      count_val;
    logic             cnt_clk;
    logic             gate;
    logic             cnt_out;
    logic [15:0]      count_now;
    int               fail_count;
    int               total_checks;
    int               m_cnt;
    int               m_init;
    bit               m_out;
    bit               m_load;
    bit               m_pend;
    bit               m_have;
    bit               m_done;
    bit               m_bcd;
    bit               m_gate;
    tsc_mode_t        m_mode;
    logic [15:0]      lfsr;

    tsc_channel u_tsc_channel (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .setup_wr   (setup_wr),
        .setup_mode (setup_mode),
        .setup_bcd  (setup_bcd),
        .count_wr   (count_wr),
        .count_val  (count_val),
        .cnt_clk    (cnt_clk),
        .gate       (gate),
        .cnt_out    (cnt_out),
        .count_now  (count_now)
    );

    tsc_pin_source u_tsc_pin_source (
        .sys_clk (sys_clk),
        .cnt_clk (cnt_clk),
        .gate    (gate)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    function automatic int dec(input int v);
        int d;
        if (!m_bcd) return (v + 65535) % 65536;
        d = 1000 * (v >> 12) + 100 * ((v >> 8) & 15) + 10 * ((v >> 4) & 15);
        d = (d + (v & 15) + 9999) % 10000;
        return ((d / 1000) << 12) | (((d / 100) % 10) << 8)
               | (((d / 10) % 10) << 4) | (d % 10);
    endfunction

    task automatic setup(input tsc_mode_t md, input logic bcd);
        setup_mode = md;
        setup_bcd = bcd;
        setup_wr = 1'b1;
        @(posedge sys_clk);
        #1 setup_wr = 1'b0;
        {m_out, m_load, m_pend, m_have, m_done, m_bcd} = {5'b10000, bcd};
        m_mode = md;
        @(posedge sys_clk);
        #1 chk({15'h0000, cnt_out}, 16'h0001);
    endtask

    task automatic wcount(input logic [15:0] v);
        count_val = v;
        count_wr = 1'b1;
        @(posedge sys_clk);
        #1 count_wr = 1'b0;
        m_init = v;
        m_have = 1'b1;
        if (m_mode == TSC_M2 && !m_load) m_pend = 1'b1;
    endtask

    task automatic trig(input int hold);
        u_tsc_pin_source.trigger(hold);
        m_pend = m_have;
    endtask

    task automatic glvl(input logic v);
        u_tsc_pin_source.level(v);
        if (v && !m_gate) m_pend = m_have;
        if (!v && m_mode == TSC_M2) m_out = 1'b1;
        m_gate = v;
    endtask

    task automatic clk(input int n);
        repeat (n) begin
            u_tsc_pin_source.half(1'b1);
            if (m_load) chk(count_now, m_cnt[15:0]);
            u_tsc_pin_source.half(1'b0);
            if (m_mode == TSC_M5) m_out = 1'b1;
            if (m_pend) begin
                {m_cnt, m_pend, m_load, m_done} = {m_init, 3'b010};
                m_out = (m_mode != TSC_M1);
            end else if (m_load && m_mode == TSC_M2) begin
                if (m_gate) begin
                    m_cnt = (m_cnt == 1) ? m_init : dec(m_cnt);
                    m_out = (m_cnt != 1);
                end
            end else if (m_load) begin
                m_cnt = dec(m_cnt);
                if (m_cnt == 0 && m_mode == TSC_M1) m_out = 1'b1;
                else if (m_cnt == 0 && !m_done) {m_out, m_done} = 2'b01;
            end
            chk({15'h0000, cnt_out}, {15'h0000, m_out});
            if (m_load) chk(count_now, m_cnt[15:0]);
        end
    endtask

    initial begin
        {sys_clk, resetn, setup_wr, setup_bcd, count_wr} = 5'b00000;
        setup_mode = TSC_M0;
        count_val = 16'h0000;
        lfsr = 16'h002D;
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1'b1;
        chk({15'h0000, cnt_out}, 16'h0000);
        chk(count_now, TSC_CNT_RST);
        setup(TSC_M5, 1'b0);
        trig(2);
        clk(2);
        wcount(16'h0004);
        clk(3);
        trig(2);
        clk(6);
        trig(3);
        clk(2);
        trig(1);
        clk(6);
        trig(2);
        clk(2);
        wcount(16'h0002);
        clk(1);
        trig(2);
        clk(4);
        glvl(1'b1);
        clk(5);
        glvl(1'b0);
        repeat (4) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            wcount({13'h0000, lfsr[2:0]} + 16'h0001);
            trig(int'(lfsr[5:4]) + 1);
            clk(int'(lfsr[2:0]) + 3);
        end
        wcount(16'h0000);
        trig(2);
        clk(3);
        setup(TSC_M5, 1'b1);
        wcount(16'h0002);
        trig(2);
        clk(5);
        trig(2);
        clk(3);
        setup(TSC_M1, 1'b0);
        wcount(16'h0003);
        trig(2);
        clk(5);
        setup(TSC_M2, 1'b0);
        glvl(1'b1);
        wcount(16'h0003);
        clk(6);
        glvl(1'b0);
        chk({15'h0000, cnt_out}, 16'h0001);
        clk(2);
        glvl(1'b1);
        clk(3);
        setup(TSC_M5, 1'b0);
        end_of_test();
    end

    // The whole run needs about a thousand cycles; this leaves ample margin.
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        end_of_test();
    end

endmodule

`default_nettype wire
